//--- src/padb_pkg.sv
/*
 Shared constants for the pipelined converter digital back end.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package padb_pkg;
	localparam int NUM_CH = 3;
	localparam int DATA_W = 8;
	localparam int WORD_W = 2;
	// Six two-bit stages plus the closing flash stage
	localparam int NUM_STG = 7;
	localparam int LAT_CYCLES = 5;
	localparam int FIFO_DEPTH = 4;
	localparam int SYNC_W = 2;
	localparam int MSB_POS = DATA_W - 1;
	localparam int STG_BUS_W = NUM_CH * NUM_STG * WORD_W;
	localparam int OUT_BUS_W = NUM_CH * DATA_W;
	localparam int SUM_W = DATA_W + 2;
	localparam logic [SUM_W-1:0] SUM_MAX = 10'h0ff;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [1:0] SYNC_RST = 2'h0;
	typedef logic [OUT_BUS_W-1:0] padb_word_t;
endpackage

//--- src/padb_stream_if.sv
/*
 Valid/ready carrier for corrected sample words between back-end modules.
 Assumes one clock shared by source and sink.
*/
`timescale 1ns/1ps
interface padb_stream_if #(parameter int WIDTH = 24);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- src/padb_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes sys_clk, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
module padb_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	padb_stream_if.snk fillSide,
	padb_stream_if.src drainSide
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	logic [WIDTH-1:0] head_reg;
	wire pushOk;
	wire popOk;
	wire [AW-1:0] rdNext;

	// ============================================================
	// Handshake
	assign fillSide.ready = (count_reg != (AW+1)'(DEPTH));
	assign drainSide.valid = (count_reg != '0);
	assign drainSide.data = head_reg;
	assign pushOk = fillSide.valid && fillSide.ready;
	assign popOk = drainSide.valid && drainSide.ready;
	assign rdNext = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;

	// ============================================================
	// Storage; head word comes out of a register
	always_ff @(posedge sys_clk) begin
		if (clkEn && pushOk) begin
			mem[wrPtr_reg] <= fillSide.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			head_reg <= '0;
		end else if (clkEn) begin
			if (pushOk) begin
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (popOk) begin
				rdPtr_reg <= rdNext;
			end
			count_reg <= count_reg + (AW+1)'(pushOk) - (AW+1)'(popOk);
			// Empty bypass keeps the head register current
			if (count_reg == '0 || (popOk && count_reg == (AW+1)'(1))) begin
				head_reg <= fillSide.data;
			end else if (popOk) begin
				head_reg <= mem[rdNext];
			end
		end
	end
endmodule

//--- src/padb_top.sv
/*
 Digital back end of a three-channel pipelined converter: phase
 generation, stage delay lines, error correction, output latching.
 Assumes the sample clock and stage comparator words arrive as pins
 asynchronous to sys_clk, which must run well above the sample clock.
*/
// Overview of operation
// R1: Three identical channels, each yields an 8-bit result, same timing.
// R2: Two non-overlapping phases, sample and hold, come from the sample clock.
// R3: Sample taken as sample phase ends; hold completes before next sample.
// R4: Each stage runs in the opposite phase to the stage before it.
// R5: Each intermediate stage gives a two-bit word with one redundant bit.
// R6: Delay lines align all stage words with the last flash word.
// R7: Correction merges aligned words using redundancy to form the sample.
// R8: Output word appears five sample cycles after its sample.
// R9: After latency, one new word each cycle for successive samples.
// R10: Corrected words pass two latch stages synchronised to sample clock.
// R11: Format-select level picks one of two numeric output formats.
// R12: Format-select low gives offset binary, high gives two's complement.
// R13: Receiver ignores output for up to 20 cycles after power-up.
// R14: Two's complement is offset binary with the top bit inverted.
`timescale 1ns/1ps
module padb_top
	import padb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic sampleClkPin,
	input wire logic [padb_pkg::STG_BUS_W-1:0] stageWordPin,
	input wire logic output_format_select,
	output logic phaseSample,
	output logic phaseHold,
	output logic [padb_pkg::OUT_BUS_W-1:0] sampleData,
	output logic dataStrobe,
	output logic stageStall
);
	import padb_pkg::*;

	// ============================================================
	// Pin synchronisers
	logic [SYNC_W-1:0] clkSync_reg;
	logic clkLast_reg;
	logic [SYNC_W-1:0] fmtSync_reg;
	logic [STG_BUS_W-1:0] stgMeta_reg;
	logic [STG_BUS_W-1:0] stgSync_reg;
	// Fills with ones once the clock synchroniser holds real pin values
	logic [SYNC_W:0] prime_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prime_reg <= '0;
		end else if (clkEn) begin
			prime_reg <= {prime_reg[SYNC_W-1:0], 1'b1};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			clkSync_reg <= SYNC_RST;
			clkLast_reg <= 1'b0;
			fmtSync_reg <= SYNC_RST;
			stgMeta_reg <= '0;
			stgSync_reg <= '0;
		end else if (clkEn) begin
			clkSync_reg <= {clkSync_reg[0], sampleClkPin};
			clkLast_reg <= clkSync_reg[1];
			fmtSync_reg <= {fmtSync_reg[0], output_format_select};
			stgMeta_reg <= stageWordPin;
			stgSync_reg <= stgMeta_reg;
		end
	end

	// ============================================================
	// Phase generation
	wire clkNow = clkSync_reg[1];
	// One dead cycle at each transition keeps the phases apart
	wire samplePhaseNext = clkNow && clkLast_reg; // R2
	wire holdPhaseNext = !clkNow && !clkLast_reg; // R2
	// Reset zeros differ from an idle-high pin; no false tick after reset
	wire primed = prime_reg[SYNC_W];
	wire sampleTick = primed && !clkNow && clkLast_reg; // R3
	wire holdTick = primed && clkNow && !clkLast_reg; // R3
	// Every phase end advances the stage pipeline by one stage
	wire halfTick = sampleTick || holdTick; // R4
	// With an odd stage count the last word of a sample lands on a hold end
	wire alignTick = holdTick; // R6
	wire fmtTwos = fmtSync_reg[1];

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			phaseSample <= 1'b0;
			phaseHold <= 1'b0;
		end else if (clkEn) begin
			phaseSample <= samplePhaseNext;
			phaseHold <= holdPhaseNext;
		end
	end

	// ============================================================
	// Delay lines and correction, one copy per channel
	padb_stream_if #(.WIDTH(OUT_BUS_W)) fillBus ();
	padb_stream_if #(.WIDTH(OUT_BUS_W)) drainBus ();
	padb_word_t corrected;
	logic corrValid_reg;
	padb_word_t corr_reg;
	wire pushStall = corrValid_reg && !fillBus.ready;

	genvar ch;
	genvar st;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch // R1
			logic [WORD_W-1:0] aligned [NUM_STG];
			for (st = 0; st < NUM_STG; st++) begin : g_stg
				localparam int BASE = (ch * NUM_STG + st) * WORD_W;
				localparam int DLY = NUM_STG - 1 - st;
				wire [WORD_W-1:0] word = stgSync_reg[BASE +: WORD_W]; // R5
				if (DLY == 0) begin : g_flash
					assign aligned[st] = word;
				end else begin : g_line
					logic [WORD_W-1:0] line_reg [DLY];
					always_ff @(posedge sys_clk) begin
						if (!rst_b) begin
							line_reg <= '{default: '0};
						end else if (clkEn && halfTick) begin
							// Earlier stages wait longer for the flash word
							line_reg[0] <= word; // R6
							for (int k = 1; k < DLY; k++) begin
								line_reg[k] <= line_reg[k-1]; // R6
							end
						end
					end
					assign aligned[st] = line_reg[DLY-1];
				end
			end

			// Overlapping one-bit weights absorb stage decision errors
			logic [SUM_W-1:0] sum;
			always_comb begin
				sum = '0;
				for (int i = 0; i < NUM_STG; i++) begin
					sum = sum + (SUM_W'(aligned[i]) << (NUM_STG - 1 - i)); // R7
				end
			end
			// Saturate: redundancy can push the sum past full scale
			assign corrected[ch*DATA_W +: DATA_W] =
				(sum > SUM_MAX) ? SUM_MAX[DATA_W-1:0] : sum[DATA_W-1:0]; // R7
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			corrValid_reg <= 1'b0;
			corr_reg <= '0;
		end else if (clkEn && !pushStall) begin
			corrValid_reg <= alignTick;
			if (alignTick) begin
				corr_reg <= corrected; // R7
			end
		end
	end

	// ============================================================
	// Buffer between correction and output latches
	assign fillBus.valid = corrValid_reg;
	assign fillBus.data = corr_reg;
	// Drained only on sample ticks so output stays tied to the sample clock
	assign drainBus.ready = sampleTick; // R9
	assign stageStall = pushStall;

	padb_fifo #(.WIDTH(OUT_BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.fillSide(fillBus),
		.drainSide(drainBus)
	);

	// ============================================================
	// Double-buffered output latches and format select
	padb_word_t latch1_reg;
	padb_word_t formatted;
	wire popNow = drainBus.valid && drainBus.ready;

	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_fmt
			assign formatted[ch*DATA_W +: DATA_W] = {
				latch1_reg[ch*DATA_W + MSB_POS] ^ fmtTwos, // R11 R12 R14
				latch1_reg[ch*DATA_W +: MSB_POS]}; // R14
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			latch1_reg <= '0;
			sampleData <= '0;
			dataStrobe <= 1'b0;
		end else if (clkEn) begin
			dataStrobe <= sampleTick; // R9
			if (popNow) begin
				latch1_reg <= drainBus.data; // R10
			end
			if (sampleTick) begin
				// Sample n enters latch two at the fifth sample tick
				sampleData <= formatted; // R8 R10
			end
		end
	end
endmodule

//--- testbench/padb_props.sv
/*
 Port assertions for the converter back end top.
 Assumes a bind into padb_top and the single sys_clk domain.
*/
`timescale 1ns/1ps
module padb_props
	import padb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic sampleClkPin,
	input wire logic output_format_select,
	input wire logic phaseSample,
	input wire logic phaseHold,
	input wire logic [padb_pkg::OUT_BUS_W-1:0] sampleData,
	input wire logic dataStrobe,
	input wire logic stageStall
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ================================================================
	// Phases and output timing
	a_phase_apart: assert property (!(phaseSample && phaseHold))
		else $error("phases overlap");
	a_sample_ends: assert property (
		$fell(sampleClkPin) |-> ##[1:4] !phaseSample)
		else $error("sample phase did not end");
	a_hold_follows: assert property (
		$fell(sampleClkPin) |-> ##[2:6] phaseHold)
		else $error("hold phase missing");
	a_sample_starts: assert property (
		$rose(sampleClkPin) |-> ##[2:6] phaseSample)
		else $error("sample phase missing");
	a_strobe_per_tick: assert property (
		$fell(sampleClkPin) |-> ##[2:6] dataStrobe)
		else $error("no word for sample tick");
	a_strobe_pulse: assert property (dataStrobe |=> !dataStrobe)
		else $error("strobe too long");
	a_data_on_tick: assert property (
		$changed(sampleData) |-> dataStrobe)
		else $error("data changed off tick");
	a_strobe_in_hold: assert property (dataStrobe |-> !phaseSample)
		else $error("strobe in sample phase");
	a_no_stall: assert property (!stageStall)
		else $error("stall at steady rate");
	c_fmt_low: cover property (dataStrobe && !output_format_select);
	c_fmt_high: cover property (dataStrobe && output_format_select);
	c_hold: cover property ($rose(phaseHold));
endmodule

bind padb_top padb_props padb_props_inst (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.sampleClkPin(sampleClkPin),
	.output_format_select(output_format_select),
	.phaseSample(phaseSample),
	.phaseHold(phaseHold),
	.sampleData(sampleData),
	.dataStrobe(dataStrobe),
	.stageStall(stageStall)
);

//--- testbench/padb_front_model.sv
/*
 Front end model: sample clock of 16 sys_clk cycles and stage words.
 Assumes it starts once run is high, after reset.
*/
`timescale 1ns/1ps
module padb_front_model
	import padb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic run,
	output logic sampleClkPin,
	output logic [padb_pkg::STG_BUS_W-1:0] stageWordPin,
	output int fallCnt
);
	int h;
	// ================================================================
	// Edge h captures stage st of sample (h-1-st)/2; words change mid
	// phase so they stand well across the capturing edge
	initial begin
		sampleClkPin = 1'b1;
		stageWordPin = '0;
		fallCnt = 0;
		h = 0;
		wait (run);
		forever begin
			repeat (4) @(posedge sys_clk);
			for (int ch = 0; ch < NUM_CH; ch++) begin
				for (int st = 0; st < NUM_STG; st++) begin
					if (h - 1 - st >= 0 && (h - 1 - st) % 2 == 0)
						stageWordPin[(ch*NUM_STG+st)*WORD_W +: WORD_W] <=
							WORD_W'(((h - 1 - st) / 2 + ch) % 4);
				end
			end
			repeat (4) @(posedge sys_clk);
			sampleClkPin <= ~sampleClkPin;
			if (sampleClkPin)
				fallCnt <= fallCnt + 1;
			h++;
		end
	end
endmodule

//--- testbench/padb_tb_top.sv
/*
 Self-checking bench for the converter back end top.
 Assumes the front end model in padb_front_model.sv.
*/
`timescale 1ns/1ps
module padb_tb_top;
	import padb_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clkEn = 1'b1;
	logic fmtSel = 1'b0;
	logic run = 1'b0;
	logic sampleClkPin;
	logic [STG_BUS_W-1:0] stageWordPin;
	logic phaseSample;
	logic phaseHold;
	logic [OUT_BUS_W-1:0] sampleData;
	logic dataStrobe;
	int fallCnt;
	int fails = 0;
	int checks = 0;
	time lastT;
	always #2.5 sys_clk = ~sys_clk;
	padb_top padb_top_inst (.sys_clk(sys_clk), .rst_b(rst_b),
		.clkEn(clkEn), .sampleClkPin(sampleClkPin),
		.stageWordPin(stageWordPin), .output_format_select(fmtSel),
		.phaseSample(phaseSample), .phaseHold(phaseHold),
		.sampleData(sampleData), .dataStrobe(dataStrobe), .stageStall());
	padb_front_model padb_front_model_inst (.sys_clk(sys_clk), .run(run),
		.sampleClkPin(sampleClkPin), .stageWordPin(stageWordPin),
		.fallCnt(fallCnt));
	// ================================================================
	// Compare and closing tasks
	task automatic check_word(string nm, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("Totals: %0d checks, %0d fails", checks, fails);
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Each stage carries w, weights 64..1 sum to 127, saturate at 255
	function automatic logic [7:0] expect_word(int m, int ch, logic f);
		int v;
		v = ((m + ch) % 4) * 127;
		v = (v > 255) ? 255 : v;
		return f ? 8'(v) ^ 8'h80 : 8'(v);
	endfunction
	task automatic wait_strobe;
		for (int k = 0; k < 40; k++) begin
			@(posedge sys_clk);
			#1;
			if (dataStrobe === 1'b1)
				break;
		end
		check_word("strobe", 8'h01, {7'h00, dataStrobe});
	endtask
	// ================================================================
	// Scenarios
	task automatic test_reset;
		repeat (20) @(posedge sys_clk);
		#1;
		check_word("phases", 8'h00, {6'h00, phaseSample, phaseHold});
		check_word("strobe rst", 8'h00, {7'h00, dataStrobe});
		check_word("data rst", 8'h00, sampleData[7:0]);
		@(posedge sys_clk) rst_b <= 1'b1;
		repeat (4) @(posedge sys_clk);
		run <= 1'b1;
		$display("test_reset done");
	endtask
	task automatic test_stream(logic f, int n);
		int m;
		wait_strobe();
		@(posedge sys_clk) fmtSel <= f;
		lastT = $time - 5;
		for (int i = 0; i < n; i++) begin
			wait_strobe();
			check_word("gap", 8'h10, 8'(($time - lastT) / 5));
			lastT = $time;
			m = fallCnt - 1 - LAT_CYCLES;
			// Early words fall in the power-up invalid window
			if (m >= 0) begin
				for (int ch = 0; ch < NUM_CH; ch++)
					check_word("sample", expect_word(m, ch, f),
						sampleData[ch*DATA_W +: DATA_W]);
			end
		end
		$display("test_stream format %0d done", f);
	endtask
	task automatic test_freeze;
		logic [OUT_BUS_W-1:0] held;
		wait_strobe();
		@(posedge sys_clk) clkEn <= 1'b0;
		#1;
		held = sampleData;
		repeat (3) @(posedge sys_clk);
		#1;
		check_word("freeze strobe", 8'h00, {7'h00, dataStrobe});
		for (int ch = 0; ch < NUM_CH; ch++)
			check_word("freeze data", held[ch*DATA_W +: DATA_W], sampleData[ch*DATA_W +: DATA_W]);
		@(posedge sys_clk) clkEn <= 1'b1;
		$display("test_freeze done");
	endtask
	initial begin
		test_reset();
		test_stream(1'b0, 12);
		test_freeze();
		test_stream(1'b1, 8);
		end_sim();
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		fails++;
		end_sim();
	end
endmodule
